/* pwm_sync_pkg.sv */
package pwm_sync_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	// word byte addresses on the bus
	localparam logic [ADDR_W-1:0] SYNC_CONFIGURATION_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] PAIR_OUTPUT_SWAP_CONTROL_ADDR = 4'h4;
	localparam logic [ADDR_W-1:0] SYNC_CONTROL_ADDR = 4'h8;
	localparam logic [ADDR_W-1:0] SYNC_STATUS_ADDR = 4'hc;
	// sync_configuration field positions
	localparam int unsigned HW_SWCTL_BIT = 20;
	localparam int unsigned HW_SWAP_BIT = 19;
	localparam int unsigned HW_MASK_BIT = 18;
	localparam int unsigned HW_WBUF_BIT = 17;
	localparam int unsigned HW_CNT_BIT = 16;
	localparam int unsigned SW_SWCTL_BIT = 12;
	localparam int unsigned SW_SWAP_BIT = 11;
	localparam int unsigned SW_MASK_BIT = 10;
	localparam int unsigned SW_WBUF_BIT = 9;
	localparam int unsigned SW_CNT_BIT = 8;
	localparam int unsigned SCHEME_BIT = 7;
	localparam int unsigned SWCTL_SEL_BIT = 5;
	localparam int unsigned SWAP_SEL_BIT = 4;
	localparam int unsigned INITVAL_SEL_BIT = 2;
	localparam int unsigned KEEP_SEL_BIT = 0;
	// writable bits of sync_configuration: 20..16, 12..7, 5, 4, 2, 0
	localparam logic [DATA_W-1:0] SYNC_CONFIGURATION_WMASK = 32'h001f_1fb5;
	localparam logic [DATA_W-1:0] SYNC_CONFIGURATION_RESET = 32'h0000_0000;
	localparam int unsigned PAIRS = 4;
	localparam logic [PAIRS-1:0] PAIR_SWAP_RESET = 4'h0;
	// sync_control bit: software trigger
	localparam int unsigned SW_TRIG_BIT = 0;
	localparam int unsigned HW_TRIGS = 3;
endpackage : pwm_sync_pkg

/* pwm_pair_swap.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_pair_swap
	import pwm_sync_pkg::*;
#(
	parameter int unsigned NPAIRS = PAIRS
) (
	input wire logic [NPAIRS-1:0] swap_en,
	input wire logic [2*NPAIRS-1:0] ch_in,
	output logic [2*NPAIRS-1:0] ch_out
);
	always_comb begin
		ch_out = ch_in;
		for (int m = 0; m < NPAIRS; m++) begin
			if (swap_en[m]) begin
				ch_out[2*m] = ch_in[2*m+1];
				ch_out[2*m+1] = ch_in[2*m];
			end
		end
	end
endmodule : pwm_pair_swap
`default_nettype wire

/* pwm_sync_config_and_inverting.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - hw trigger syncs software output control if enabled
// - hw trigger syncs swap control if enabled
// - hw trigger syncs output mask if enabled
// - hw trigger syncs modulo/initial/channel if enabled
// - hw trigger resets counter if enabled
// - sw trigger syncs software output control if enabled
// - sw trigger syncs swap control if enabled
// - sw trigger syncs output mask if enabled
// - sw trigger syncs modulo/initial/channel if enabled
// - sw trigger resets counter if enabled
// - scheme bit picks legacy or enhanced
// - swctl select: every clock or sync only
// - swap select: every clock or sync only
// - initval select: every clock or sync only
// - keep bit decides clearing trigger enables
// - reserved bits read zero, ignore writes
// - enabled pair swaps its two outputs
// - swap register written via buffer only
module pwm_sync_config_and_inverting
	import pwm_sync_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [HW_TRIGS-1:0] hw_trig_in,
	input wire logic [HW_TRIGS-1:0] hw_trigger_enable_j,
	input wire logic [2*PAIRS-1:0] ch_in,
	output logic [2*PAIRS-1:0] ch_out,
	output logic [HW_TRIGS-1:0] trig_enable_clear,
	output logic swctl_load,
	output logic mask_load,
	output logic wbuf_load,
	output logic initval_load,
	output logic cnt_sync,
	output logic sync_scheme_select
);
	logic [DATA_W-1:0] sync_configuration_q;
	logic [PAIRS-1:0] pair_swap_buf_q;
	logic [PAIRS-1:0] pair_swap_reg_q;
	logic [HW_TRIGS-1:0] hw_s1_q;
	logic [HW_TRIGS-1:0] hw_s2_q;
	logic [HW_TRIGS-1:0] hw_s3_q;
	logic sw_trig_q;
	// bus handshake
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_e;
	bus_state_e bus_state_q;
	logic in_ack;
	logic [7:0] hw_count_q;
	logic [2*PAIRS-1:0] swapped;
	logic [HW_TRIGS-1:0] hw_det;
	logic hw_any;
	logic acc;
	logic wr;
	logic hw_swctl;
	logic hw_swap;
	logic hw_mask;
	logic hw_wbuf;
	logic hw_cnt;
	logic sw_swctl;
	logic sw_swap;
	logic sw_mask;
	logic sw_wbuf;
	logic sw_cnt;
	// decoded fields of sync_configuration
	logic hw_trig_swctl_sync_en;
	logic hw_trig_swap_sync_en;
	logic hw_trig_mask_sync_en;
	logic hw_trig_wbuf_sync_en;
	logic hw_trig_cnt_sync_en;
	logic sw_trig_swctl_sync_en;
	logic sw_trig_swap_sync_en;
	logic sw_trig_mask_sync_en;
	logic sw_trig_wbuf_sync_en;
	logic sw_trig_cnt_sync_en;
	logic swctl_update_select;
	logic swap_update_select;
	logic initval_update_select;
	logic trig_flag_keep_select;

	function automatic logic [DATA_W-1:0] merge_be(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : merge_be

	// single-lane registers only listen to byte lane 0
	function automatic logic lane0_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target,
		input logic [3:0] be);
		return a == target && be[0];
	endfunction : lane0_hit

	// unmapped and write-only offsets read as zero
	function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] cfg, input logic [PAIRS-1:0] swap_act,
		input logic [PAIRS-1:0] swap_buf, input logic [7:0] count);
		logic [DATA_W-1:0] r;
		case (a)
			SYNC_CONFIGURATION_ADDR: r = cfg;
			PAIR_OUTPUT_SWAP_CONTROL_ADDR: r = {{(DATA_W-PAIRS){1'b0}}, swap_act};
			SYNC_STATUS_ADDR: r = {16'h0000, count, 4'h0, swap_buf};
			default: r = '0;
		endcase
		return r;
	endfunction : read_mux

	// one wait state per access, so readdata is registered
	assign in_ack = bus_state_q == BUS_ACK;
	assign acc = (avs_read | avs_write) & ~in_ack;
	// writes land only at the edge that ends the ack cycle, one edge after the wait state ends
	assign wr = avs_write & in_ack;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_state_q <= BUS_IDLE;
		end else begin
			case (bus_state_q)
				BUS_IDLE: begin
					if (acc) begin
						bus_state_q <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					bus_state_q <= BUS_IDLE;
				end
				default: begin
					bus_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// registered so the pin comes straight from a flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~acc;
		end
	end

	// trigger pins are asynchronous: two flops before use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hw_s1_q <= '0;
			hw_s2_q <= '0;
		end else begin
			hw_s1_q <= hw_trig_in;
			hw_s2_q <= hw_s1_q;
		end
	end

	// edge history reads only the second stage, never the first
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hw_s3_q <= '0;
		end else begin
			hw_s3_q <= hw_s2_q;
		end
	end

	// rising edge of an enabled trigger counts as detected
	assign hw_det = hw_s2_q & ~hw_s3_q & hw_trigger_enable_j;
	assign hw_any = |hw_det;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_configuration_q <= SYNC_CONFIGURATION_RESET;
		end else if (wr && avs_address == SYNC_CONFIGURATION_ADDR) begin
			sync_configuration_q <= merge_be(sync_configuration_q, avs_writedata, avs_byteenable)
				& SYNC_CONFIGURATION_WMASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pair_swap_buf_q <= PAIR_SWAP_RESET;
		end else if (wr && lane0_hit(avs_address, PAIR_OUTPUT_SWAP_CONTROL_ADDR, avs_byteenable)) begin
			pair_swap_buf_q <= avs_writedata[PAIRS-1:0];
		end
	end

	// software trigger is a one-shot; self clears on the next cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_trig_q <= 1'b0;
		end else begin
			sw_trig_q <= wr && lane0_hit(avs_address, SYNC_CONTROL_ADDR, avs_byteenable)
				&& avs_writedata[SW_TRIG_BIT];
		end
	end

	assign hw_trig_swctl_sync_en = sync_configuration_q[HW_SWCTL_BIT];
	assign hw_trig_swap_sync_en = sync_configuration_q[HW_SWAP_BIT];
	assign hw_trig_mask_sync_en = sync_configuration_q[HW_MASK_BIT];
	assign hw_trig_wbuf_sync_en = sync_configuration_q[HW_WBUF_BIT];
	assign hw_trig_cnt_sync_en = sync_configuration_q[HW_CNT_BIT];
	assign sw_trig_swctl_sync_en = sync_configuration_q[SW_SWCTL_BIT];
	assign sw_trig_swap_sync_en = sync_configuration_q[SW_SWAP_BIT];
	assign sw_trig_mask_sync_en = sync_configuration_q[SW_MASK_BIT];
	assign sw_trig_wbuf_sync_en = sync_configuration_q[SW_WBUF_BIT];
	assign sw_trig_cnt_sync_en = sync_configuration_q[SW_CNT_BIT];
	assign swctl_update_select = sync_configuration_q[SWCTL_SEL_BIT];
	assign swap_update_select = sync_configuration_q[SWAP_SEL_BIT];
	assign initval_update_select = sync_configuration_q[INITVAL_SEL_BIT];
	assign trig_flag_keep_select = sync_configuration_q[KEEP_SEL_BIT];

	assign hw_swctl = hw_any & hw_trig_swctl_sync_en;
	assign hw_swap = hw_any & hw_trig_swap_sync_en;
	assign hw_mask = hw_any & hw_trig_mask_sync_en;
	assign hw_wbuf = hw_any & hw_trig_wbuf_sync_en;
	assign hw_cnt = hw_any & hw_trig_cnt_sync_en;
	assign sw_swctl = sw_trig_q & sw_trig_swctl_sync_en;
	assign sw_swap = sw_trig_q & sw_trig_swap_sync_en;
	assign sw_mask = sw_trig_q & sw_trig_mask_sync_en;
	assign sw_wbuf = sw_trig_q & sw_trig_wbuf_sync_en;
	assign sw_cnt = sw_trig_q & sw_trig_cnt_sync_en;

	// active swap bits move only by sync or by free-running update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pair_swap_reg_q <= PAIR_SWAP_RESET;
		end else if (!swap_update_select || hw_swap || sw_swap) begin
			pair_swap_reg_q <= pair_swap_buf_q;
		end
	end

	pwm_pair_swap #(
		.NPAIRS(PAIRS)
	) u_swap (
		.swap_en(pair_swap_reg_q),
		.ch_in(ch_in),
		.ch_out(swapped)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ch_out <= '0;
		end else begin
			ch_out <= swapped;
		end
	end

	// load strobes to the buffered registers held elsewhere
	// level while the select is clear, pulse per sync otherwise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			swctl_load <= 1'b0;
		end else begin
			swctl_load <= !swctl_update_select || hw_swctl || sw_swctl;
		end
	end

	// pulses only: the mask has no free-running update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_load <= 1'b0;
		end else begin
			mask_load <= hw_mask || sw_mask;
		end
	end

	// modulo and channel values move together; initial value joins them only when its select is set
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wbuf_load <= 1'b0;
		end else begin
			wbuf_load <= hw_wbuf || sw_wbuf;
		end
	end

	// rides on the write-buffer sync when the select is set
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			initval_load <= 1'b0;
		end else begin
			initval_load <= !initval_update_select || hw_wbuf || sw_wbuf;
		end
	end

	// counter restart request, one cycle wide
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_sync <= 1'b0;
		end else begin
			cnt_sync <= hw_cnt || sw_cnt;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_enable_clear <= '0;
		end else begin
			// pulse per detected trigger unless the keep bit is set; the enable bit itself lives outside
			trig_enable_clear <= trig_flag_keep_select ? '0 : hw_det;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_scheme_select <= 1'b0;
		end else begin
			// a flop copy keeps the output free of bus decode glitches
			sync_scheme_select <= sync_configuration_q[SCHEME_BIT];
		end
	end

	// counts hardware triggers seen, visible in status
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hw_count_q <= 8'h00;
		end else if (hw_any) begin
			hw_count_q <= hw_count_q + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= '0;
		end else if (avs_read && !in_ack) begin
			avs_readdata <= read_mux(avs_address, sync_configuration_q, pair_swap_reg_q, pair_swap_buf_q,
				hw_count_q);
		end
	end
endmodule : pwm_sync_config_and_inverting
`default_nettype wire

/* pwm_sync_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_sync_monitor
	import pwm_sync_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [HW_TRIGS-1:0] hw_trigger_enable_j,
	input wire logic [2*PAIRS-1:0] ch_in,
	input wire logic [2*PAIRS-1:0] ch_out,
	input wire logic [HW_TRIGS-1:0] trig_enable_clear,
	input wire logic mask_load,
	input wire logic wbuf_load,
	input wire logic cnt_sync,
	input wire logic sync_scheme_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2*PAIRS-1:0] ch_in_q;
	// swap state is hidden, so only the pair-symmetry of the change is checked
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) ch_in_q <= '0;
		else ch_in_q <= ch_in;
	end
	wire logic [2*PAIRS-1:0] d = ch_out ^ ch_in_q;
	property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("ack held");
	property p_ans; (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("no ack");
	property p_clr; (trig_enable_clear & $past(trig_enable_clear)) == '0; endproperty
	a_clr: assert property (p_clr) else $error("clear held");
	property p_clr_en; (trig_enable_clear & ~($past(hw_trigger_enable_j) | $past(hw_trigger_enable_j, 2))) == '0;
	endproperty
	a_clr_en: assert property (p_clr_en) else $error("clear unarmed");
	property p_swap; {d[7], d[5], d[3], d[1]} == {d[6], d[4], d[2], d[0]}; endproperty
	a_swap: assert property (p_swap) else $error("bad swap");
	property p_scheme; $changed(sync_scheme_select) |-> $past(avs_write) || $past(avs_write, 2); endproperty
	a_scheme: assert property (p_scheme) else $error("scheme moved");
	property p_mask; mask_load |=> !mask_load; endproperty
	a_mask: assert property (p_mask) else $error("mask held");
	property p_wbuf; wbuf_load |=> !wbuf_load; endproperty
	a_wbuf: assert property (p_wbuf) else $error("wbuf held");
	property p_cnt; cnt_sync |=> !cnt_sync; endproperty
	a_cnt: assert property (p_cnt) else $error("cnt held");
	c_clr: cover property (trig_enable_clear != '0);
	c_swap: cover property (d != '0);
	c_mask: cover property (mask_load);
endmodule : pwm_sync_monitor
bind pwm_sync_config_and_inverting pwm_sync_monitor u_mon (.clk, .sys_rst, .avs_read, .avs_write,
	.avs_waitrequest, .hw_trigger_enable_j, .ch_in, .ch_out, .trig_enable_clear, .mask_load, .wbuf_load,
	.cnt_sync, .sync_scheme_select);
`default_nettype wire

/* pwm_sync_config_and_inverting_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_sync_config_and_inverting_tb;
	import pwm_sync_pkg::*;
	localparam logic [DATA_W-1:0] SEL = 32'h0000_0034;
	localparam logic [ADDR_W-1:0] CFG = SYNC_CONFIGURATION_ADDR;
	localparam logic [ADDR_W-1:0] SWP = PAIR_OUTPUT_SWAP_CONTROL_ADDR;
	logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [DATA_W-1:0] avs_writedata = '0, avs_readdata;
	logic [HW_TRIGS-1:0] hw_trig_in = '0, hw_trigger_enable_j = '0, trig_enable_clear;
	logic [2*PAIRS-1:0] ch_in = 8'h5a, ch_out;
	logic avs_waitrequest, swctl_load, mask_load, wbuf_load, initval_load, cnt_sync, sync_scheme_select;
	int n_fail = 0;
	int num_checks = 0;
	pwm_sync_config_and_inverting uut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .hw_trig_in, .hw_trigger_enable_j, .ch_in,
		.ch_out, .trig_enable_clear, .swctl_load, .mask_load, .wbuf_load, .initval_load, .cnt_sync,
		.sync_scheme_select);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, output logic [DATA_W-1:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		logic [DATA_W-1:0] q;
		bus(1'b1, a, v, q);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] q;
		bus(1'b0, a, '0, q);
		chk(q, exp);
	endtask : rd
	// strobes are collected over a window since their exact cycle is the design's choice
	task automatic fire(input logic hw, output logic [5:0] seen);
		logic [DATA_W-1:0] q;
		seen = '0;
		if (hw) hw_trig_in <= 3'b001;
		else bus(1'b1, SYNC_CONTROL_ADDR, 32'h1, q);
		repeat (8) begin
			@(posedge clk);
			seen |= {swctl_load, mask_load, wbuf_load, cnt_sync, |trig_enable_clear, initval_load};
		end
		hw_trig_in <= '0;
	endtask : fire
	task automatic t_regs;
		rd(CFG, SYNC_CONFIGURATION_RESET);
		rd(SWP, 32'h0);
		wr(CFG, 32'hffff_ffff);
		rd(CFG, SYNC_CONFIGURATION_WMASK);
		chk(sync_scheme_select, 1'b1);
		wr(CFG, 32'h0);
		rd(SYNC_CONTROL_ADDR, 32'h0);
		chk(sync_scheme_select, 1'b0);
		wr(SWP, 32'hffff_ffff);
		rd(SWP, 32'hf);
		chk(swctl_load, 1'b1);
		chk(initval_load, 1'b1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_sw;
		int b[5] = '{12, 10, 9, 8, 11};
		logic [5:0] seen;
		wr(SWP, 32'h0);
		wr(CFG, SEL);
		wr(SWP, 32'hf);
		rd(SWP, 32'h0);
		foreach (b[i]) begin
			wr(CFG, SEL | (32'h1 << b[i]));
			fire(1'b0, seen);
			chk(seen, {b[i] == 12, b[i] == 10, b[i] == 9, b[i] == 8, 1'b0, b[i] == 9});
		end
		rd(SWP, 32'hf);
		chk(ch_out, 8'ha5);
		$display("t_sw done");
	endtask : t_sw
	task automatic t_hw;
		int b[5] = '{20, 18, 17, 16, 19};
		logic [5:0] seen;
		hw_trigger_enable_j <= 3'b001;
		wr(SWP, 32'h0);
		foreach (b[i]) begin
			wr(CFG, SEL | (32'h1 << b[i]) | (32'(b[i] == 18) << KEEP_SEL_BIT));
			fire(1'b1, seen);
			chk(seen, {b[i] == 20, b[i] == 18, b[i] == 17, b[i] == 16, b[i] != 18, b[i] == 17});
		end
		rd(SWP, 32'h0);
		chk(ch_out, 8'h5a);
		rd(SYNC_STATUS_ADDR, 32'h0000_0500);
		$display("t_hw done");
	endtask : t_hw
	task automatic stop_test;
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_sw;
		t_hw;
		stop_test;
	end
endmodule : pwm_sync_config_and_inverting_tb
`default_nettype wire
